// ---- verilog/ulc_top.v ----
`timescale 1ns/10ps
`default_nettype none

module ulc_top
(
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  paddr_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        serial_in_i,
  output wire        serial_out_o,
  output wire        infrared_tx_out_o,
  output wire        irq_o
);

`include "ulc_defs.vh"

  localparam TX_IDLE  = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA  = 3'h2;
  localparam TX_PAR   = 3'h3;
  localparam TX_STOP  = 3'h4;

  localparam integer MIDI_DIV_FULL = `ULC_CLK_HZ / (`ULC_OVERSAMPLE * `ULC_MIDI_BAUD);
  localparam [15:0]  MIDI_DIV      = MIDI_DIV_FULL[15:0];

  reg  [7:0]  line_control_reg_q;
  reg  [15:0] divisor_q;
  reg  [`ULC_EV_WIDTH-1:0] ien_q;
  reg  [`ULC_EV_WIDTH-1:0] ist_q;
  reg         midi_q;
  reg  [7:0]  scratch_q;
  reg         overrun_q;
  reg         par_err_q;
  reg         stop_err_q;
  reg         tx_empty_q;
  reg  [15:0] baud_cnt_q;
  reg         tick_q;
  reg  [2:0]  tx_state_q;
  reg  [4:0]  tx_cnt_q;
  reg  [2:0]  tx_bit_q;
  reg  [7:0]  tx_shift_q;
  reg         tx_par_q;
  reg         serial_out_q;
  reg  [7:0]  rd_mux;

  wire [2:0]  idx;
  wire        mapped;
  wire        setup;
  wire        wr_acc;
  wire        rd_acc;
  wire        dlab;
  wire [1:0]  word_len;
  wire        pen;
  wire        even_sel;
  wire        fixed_par;
  wire [15:0] div_eff;
  wire [7:0]  tx_mask;
  wire [4:0]  stop_last;
  wire        tx_push;
  wire        tx_valid;
  wire [7:0]  tx_data;
  wire        tx_pop;
  wire [4:0]  tx_count;
  wire        rx_valid;
  wire [7:0]  rx_data;
  wire        rx_pop;
  wire        rx_ready;
  wire        rx_done;
  wire [7:0]  rx_char;
  wire        rx_par_err;
  wire        rx_stop_err;
  wire        rx_flush;
  wire        tx_flush;
  wire        lsr_read;
  wire        ovr_ev;
  wire [`ULC_EV_WIDTH-1:0] events;
  wire [`ULC_EV_WIDTH-1:0] ist_clr;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, index 6 and high addresses are unmapped.
  assign idx       = paddr_i[4:2];
  assign mapped    = (paddr_i[7:5] == 3'h0) && (idx != `ULC_IDX_HOLE);
  assign setup     = psel_i & ~penable_i;
  assign wr_acc    = psel_i & penable_i & pwrite_i & mapped;
  assign rd_acc    = psel_i & penable_i & ~pwrite_i & mapped;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Line control fields.
  assign dlab      = line_control_reg_q[`ULC_LC_DLAB];
  assign word_len  = line_control_reg_q[`ULC_LC_WLEN_HI:`ULC_LC_WLEN_LO];
  assign pen       = line_control_reg_q[`ULC_LC_PEN];
  assign even_sel  = line_control_reg_q[`ULC_LC_EVEN];
  assign fixed_par = line_control_reg_q[`ULC_LC_FIXED];

  // Access side effects; only the data register push and pop depend on the divisor access bit.
  assign tx_push  = wr_acc & (idx == `ULC_IDX_DATA) & ~dlab;
  assign rx_pop   = rd_acc & (idx == `ULC_IDX_DATA) & ~dlab;
  assign lsr_read = rd_acc & (idx == `ULC_IDX_LSR);
  assign rx_flush = wr_acc & (idx == `ULC_IDX_MODE) & pwdata_i[`ULC_MD_RX_FLUSH];
  assign tx_flush = wr_acc & (idx == `ULC_IDX_MODE) & pwdata_i[`ULC_MD_TX_FLUSH];
  assign ist_clr  = (wr_acc && idx == `ULC_IDX_IST) ?
                    pwdata_i[`ULC_EV_WIDTH-1:0] : {`ULC_EV_WIDTH{1'b0}};

  // Read data for the current address, captured in the setup cycle.
  always @*
  begin
    case (idx)
      `ULC_IDX_DATA:    rd_mux = dlab ? divisor_q[7:0] : rx_data;
      `ULC_IDX_IEN:     rd_mux = dlab ? divisor_q[15:8] :
                                 {5'h00, ien_q};
      `ULC_IDX_IST:     rd_mux = {5'h00, ist_q};
      `ULC_IDX_LCR:     rd_mux = line_control_reg_q;
      `ULC_IDX_MODE:    rd_mux = {7'h00, midi_q};
      `ULC_IDX_LSR:     rd_mux = {1'b0, ~tx_valid & (tx_state_q == TX_IDLE),
                                  ~tx_valid, 1'b0, stop_err_q, par_err_q,
                                  overrun_q, rx_valid};
      `ULC_IDX_SCRATCH: rd_mux = scratch_q;
      default:          rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and registered read data.
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      line_control_reg_q <= `ULC_LC_RESET;
      divisor_q          <= 16'h0001;
      ien_q              <= {`ULC_EV_WIDTH{1'b0}};
      midi_q             <= 1'b0;
      scratch_q          <= 8'h00;
      prdata_o           <= 32'h0000_0000;
    end
    else
    begin
      if (setup)
        prdata_o <= {24'h00_0000, rd_mux};
      if (wr_acc)
      begin
        case (idx)
          `ULC_IDX_DATA:
            if (dlab)
              divisor_q[7:0] <= pwdata_i[7:0];
          `ULC_IDX_IEN:
            if (dlab)
              divisor_q[15:8] <= pwdata_i[7:0];
            else
              ien_q <= pwdata_i[`ULC_EV_WIDTH-1:0];
          `ULC_IDX_LCR:     line_control_reg_q <= pwdata_i[7:0];
          `ULC_IDX_MODE:    midi_q <= pwdata_i[`ULC_MD_MIDI];
          `ULC_IDX_SCRATCH: scratch_q <= pwdata_i[7:0];
          default:          scratch_q <= scratch_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator; a zero divisor acts as one rather than stalling.
  assign div_eff = midi_q ? MIDI_DIV :
                   ((divisor_q == 16'h0000) ? 16'h0001 : divisor_q);

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      baud_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end
    else if (baud_cnt_q >= div_eff - 16'h0001)
    begin
      baud_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end
    else
    begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queues on both directions.
  ulc_fifo u_tx_fifo
  (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .flush_i    (tx_flush),
    .wr_valid_i (tx_push),
    .wr_ready_o (),               // A full queue drops the write.
    .wr_data_i  (pwdata_i[7:0]),
    .rd_valid_o (tx_valid),
    .rd_ready_i (tx_pop),
    .rd_data_o  (tx_data),
    .count_o    (tx_count)
  );

  ulc_fifo u_rx_fifo
  (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .flush_i    (rx_flush),
    .wr_valid_i (rx_done),
    .wr_ready_o (rx_ready),
    .wr_data_i  (rx_char),
    .rd_valid_o (rx_valid),
    .rd_ready_i (rx_pop),
    .rd_data_o  (rx_data),
    .count_o    ()
  );

  ulc_rx u_rx
  (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .tick_i      (tick_q),
    .serial_in_i (serial_in_i),
    .word_len_i  (word_len),
    .parity_en_i (pen),
    .fixed_par_i (fixed_par),
    .even_sel_i  (even_sel),
    .done_o      (rx_done),
    .data_o      (rx_char),
    .par_err_o   (rx_par_err),
    .stop_err_o  (rx_stop_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: one sixteen-tick slot per bit, stop length in ticks.
  assign tx_mask   = ~(8'he0 << word_len);
  assign stop_last = !line_control_reg_q[`ULC_LC_MSTOP] ? `ULC_STOP_ONE :
                     (word_len == 2'b00) ? `ULC_STOP_ONE_HALF : `ULC_STOP_TWO;
  assign tx_pop    = tick_q & (tx_state_q == TX_IDLE) & tx_valid;

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      tx_state_q   <= TX_IDLE;
      tx_cnt_q     <= 5'h00;
      tx_bit_q     <= 3'h0;
      tx_shift_q   <= 8'h00;
      tx_par_q     <= 1'b0;
      serial_out_q <= 1'b1;
    end
    else if (tick_q)
    begin
      tx_cnt_q <= tx_cnt_q + 5'h01;
      case (tx_state_q)
        TX_IDLE:
        begin
          tx_cnt_q     <= 5'h00;
          serial_out_q <= 1'b1;
          if (tx_valid)
          begin
            tx_shift_q   <= tx_data & tx_mask;
            tx_par_q     <= fixed_par ? ~even_sel :
                            (even_sel ? ^(tx_data & tx_mask) :
                             ~^(tx_data & tx_mask));
            serial_out_q <= 1'b0;
            tx_state_q   <= TX_START;
          end
        end
        TX_START:
        begin
          if (tx_cnt_q == `ULC_TICK_LAST)
          begin
            tx_cnt_q     <= 5'h00;
            tx_bit_q     <= 3'h0;
            serial_out_q <= tx_shift_q[0];
            tx_state_q   <= TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (tx_cnt_q == `ULC_TICK_LAST)
          begin
            tx_cnt_q   <= 5'h00;
            tx_bit_q   <= tx_bit_q + 3'h1;
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            if (tx_bit_q == {1'b1, word_len})
            begin
              serial_out_q <= pen ? tx_par_q : 1'b1;
              tx_state_q   <= pen ? TX_PAR : TX_STOP;
            end
            else
              serial_out_q <= tx_shift_q[1];
          end
        end
        TX_PAR:
        begin
          if (tx_cnt_q == `ULC_TICK_LAST)
          begin
            tx_cnt_q     <= 5'h00;
            serial_out_q <= 1'b1;
            tx_state_q   <= TX_STOP;
          end
        end
        TX_STOP:
        begin
          if (tx_cnt_q == stop_last)
            tx_state_q <= TX_IDLE;
        end
        default:
          tx_state_q <= TX_IDLE;
      endcase
    end
  end

  assign serial_out_o      = serial_out_q;
  // Silence touches only the infrared copy of the line.
  assign infrared_tx_out_o = serial_out_q & ~line_control_reg_q[`ULC_LC_SILENCE];

  ////////////////////////////////////////////////////////////////////////////
  // Line errors and interrupt status; a new event beats a same-cycle clear.
  assign ovr_ev = rx_done & ~rx_ready;
  assign events = {rx_done & (rx_par_err | rx_stop_err | ~rx_ready),
                   tx_count == 5'h00 && !tx_empty_q,
                   rx_done & rx_ready};

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      overrun_q  <= 1'b0;
      par_err_q  <= 1'b0;
      stop_err_q <= 1'b0;
      tx_empty_q <= 1'b1;
      ist_q      <= {`ULC_EV_WIDTH{1'b0}};
    end
    else
    begin
      overrun_q  <= ovr_ev | (overrun_q & ~lsr_read);
      par_err_q  <= (rx_done & rx_par_err) | (par_err_q & ~lsr_read);
      stop_err_q <= (rx_done & rx_stop_err) | (stop_err_q & ~lsr_read);
      tx_empty_q <= (tx_count == 5'h00);
      ist_q      <= events | (ist_q & ~ist_clr);
    end
  end

  assign irq_o = |(ist_q & ien_q);

endmodule

`default_nettype wire

// ---- verilog/ulc_defs.vh ----
`ifndef ULC_DEFS_VH
`define ULC_DEFS_VH

// Register indexes; the APB byte address is four times the index.
`define ULC_IDX_DATA      3'h0
`define ULC_IDX_IEN       3'h1
`define ULC_IDX_IST       3'h2
`define ULC_IDX_LCR       3'h3
`define ULC_IDX_MODE      3'h4
`define ULC_IDX_LSR       3'h5
`define ULC_IDX_HOLE      3'h6
`define ULC_IDX_SCRATCH   3'h7

// Line control fields.
`define ULC_LC_WLEN_LO    0
`define ULC_LC_WLEN_HI    1
`define ULC_LC_MSTOP      2
`define ULC_LC_PEN        3
`define ULC_LC_EVEN       4
`define ULC_LC_FIXED      5
`define ULC_LC_SILENCE    6
`define ULC_LC_DLAB       7
`define ULC_LC_RESET      8'h00

// Mode register fields.
`define ULC_MD_MIDI       0
`define ULC_MD_RX_FLUSH   1
`define ULC_MD_TX_FLUSH   2

// Interrupt event bits.
`define ULC_EV_RX         0
`define ULC_EV_TX_EMPTY   1
`define ULC_EV_RX_ERR     2
`define ULC_EV_WIDTH      3

// Line status bits.
`define ULC_LS_RX_READY   0
`define ULC_LS_OVERRUN    1
`define ULC_LS_PAR_ERR    2
`define ULC_LS_STOP_ERR   3
`define ULC_LS_TX_EMPTY   5
`define ULC_LS_TX_IDLE    6

// Bit timing in ticks of the sixteen-times clock.
`define ULC_TICK_HALF     5'h07
`define ULC_TICK_LAST     5'h0f
`define ULC_STOP_ONE      5'h0f
`define ULC_STOP_ONE_HALF 5'h17
`define ULC_STOP_TWO      5'h1f

// Clock rate and the fixed MIDI bit rate.
`define ULC_CLK_HZ        20000000
`define ULC_MIDI_BAUD     31250
`define ULC_OVERSAMPLE    16

`define ULC_FIFO_DEPTH    16
`define ULC_FIFO_AW       4

`endif

// ---- verilog/ulc_fifo.v ----
`timescale 1ns/10ps
`default_nettype none

// Sixteen-byte first-in first-out queue held in flip-flops.
module ulc_fifo
(
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire       flush_i,
  input  wire       wr_valid_i,
  output wire       wr_ready_o,
  input  wire [7:0] wr_data_i,
  output wire       rd_valid_o,
  input  wire       rd_ready_i,
  output wire [7:0] rd_data_o,
  output wire [4:0] count_o
);

`include "ulc_defs.vh"

  reg [7:0]               mem_q [0:`ULC_FIFO_DEPTH-1];
  reg [`ULC_FIFO_AW-1:0]  wptr_q;
  reg [`ULC_FIFO_AW-1:0]  rptr_q;
  reg [4:0]               cnt_q;
  wire                    push;
  wire                    pop;

  // Full and empty come from the occupancy count, so both are exact.
  assign wr_ready_o = (cnt_q != 5'h10);
  assign rd_valid_o = (cnt_q != 5'h00);
  assign rd_data_o  = mem_q[rptr_q];
  assign count_o    = cnt_q;
  assign push       = wr_valid_i & wr_ready_o;
  assign pop        = rd_ready_i & rd_valid_o;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and count update; a flush empties the queue at once.
  always @(posedge mclk_i)
  begin
    if (!rst_n_i || flush_i)
    begin
      wptr_q <= {`ULC_FIFO_AW{1'b0}};
      rptr_q <= {`ULC_FIFO_AW{1'b0}};
      cnt_q  <= 5'h00;
    end
    else
    begin
      if (push)
        wptr_q <= wptr_q + 4'h1;
      if (pop)
        rptr_q <= rptr_q + 4'h1;
      if (push && !pop)
        cnt_q <= cnt_q + 5'h01;
      else if (pop && !push)
        cnt_q <= cnt_q - 5'h01;
    end
  end

  // Storage needs no reset; only written slots are ever read.
  always @(posedge mclk_i)
  begin
    if (push)
      mem_q[wptr_q] <= wr_data_i;
  end

endmodule

`default_nettype wire

// ---- verilog/ulc_rx.v ----
`timescale 1ns/10ps
`default_nettype none

// Serial receiver timed by the sixteen-times bit clock.
module ulc_rx
(
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire       tick_i,
  input  wire       serial_in_i,
  input  wire [1:0] word_len_i,
  input  wire       parity_en_i,
  input  wire       fixed_par_i,
  input  wire       even_sel_i,
  output reg        done_o,
  output reg  [7:0] data_o,
  output reg        par_err_o,
  output reg        stop_err_o
);

`include "ulc_defs.vh"

  localparam RX_IDLE  = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA  = 3'h2;
  localparam RX_PAR   = 3'h3;
  localparam RX_STOP  = 3'h4;

  reg  [2:0] state_q;
  reg  [4:0] cnt_q;
  reg  [2:0] bit_q;
  reg  [7:0] shift_q;
  reg        par_q;
  wire [7:0] mask;
  wire       exp_par;

  // Expected parity over the received data bits only.
  assign mask    = ~(8'he0 << word_len_i);
  assign exp_par = fixed_par_i ? ~even_sel_i :
                   (even_sel_i ? ^(shift_q & mask) : ~^(shift_q & mask));

  ////////////////////////////////////////////////////////////////////////////
  // Start confirmation at mid bit, then one sample per bit at its centre.
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state_q    <= RX_IDLE;
      cnt_q      <= 5'h00;
      bit_q      <= 3'h0;
      shift_q    <= 8'h00;
      par_q      <= 1'b0;
      done_o     <= 1'b0;
      data_o     <= 8'h00;
      par_err_o  <= 1'b0;
      stop_err_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (tick_i)
      begin
        cnt_q <= cnt_q + 5'h01;
        case (state_q)
          RX_IDLE:
          begin
            cnt_q <= 5'h00;
            if (!serial_in_i)
            begin
              state_q <= RX_START;
              shift_q <= 8'h00;
            end
          end
          RX_START:
          begin
            if (cnt_q == `ULC_TICK_HALF)
            begin
              cnt_q   <= 5'h00;
              bit_q   <= 3'h0;
              // A glitch shorter than half a bit is not a start bit.
              state_q <= serial_in_i ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA:
          begin
            if (cnt_q == `ULC_TICK_LAST)
            begin
              cnt_q          <= 5'h00;
              shift_q[bit_q] <= serial_in_i;
              bit_q          <= bit_q + 3'h1;
              if (bit_q == {1'b1, word_len_i})
                state_q <= parity_en_i ? RX_PAR : RX_STOP;
            end
          end
          RX_PAR:
          begin
            if (cnt_q == `ULC_TICK_LAST)
            begin
              cnt_q   <= 5'h00;
              par_q   <= serial_in_i;
              state_q <= RX_STOP;
            end
          end
          RX_STOP:
          begin
            // Finishing at the first stop bit centre leaves room to catch
            // a start bit that follows the shortest stop time.
            if (cnt_q == `ULC_TICK_LAST)
            begin
              done_o     <= 1'b1;
              data_o     <= shift_q;
              stop_err_o <= ~serial_in_i;
              par_err_o  <= parity_en_i & (par_q != exp_par);
              state_q    <= RX_IDLE;
            end
          end
          default:
            state_q <= RX_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ---- tb/ulc_top_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

module ulc_chk
(
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  input wire logic        serial_out_o,
  input wire logic        infrared_tx_out_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Cycles since the line last moved; it saturates so long idle time never wraps.
  logic [4:0] run_q;
  logic       last_q;
  always_ff @(posedge mclk_i)
  begin
    last_q <= serial_out_o;
    if (!rst_n_i || serial_out_o != last_q)
      run_q <= rst_n_i ? 5'h00 : 5'h1f;
    else if (run_q != 5'h1f)
      run_q <= run_q + 5'h01;
  end

  ////////////////////////////////////////
  property p_idle;
    $rose(rst_n_i) |-> serial_out_o && infrared_tx_out_o;
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle after reset");
  property p_bit;
    $changed(serial_out_o) |-> run_q >= 5'h0f;
  endproperty
  a_bit: assert property (p_bit) else $error("bit shorter than sixteen ticks");
  property p_zero;
    $fell(serial_out_o) |=> !serial_out_o [*7];
  endproperty
  a_zero: assert property (p_zero) else $error("low bit cut short");
  property p_ir;
    infrared_tx_out_o |-> serial_out_o;
  endproperty
  a_ir: assert property (p_ir) else $error("infrared differs from line");
  property p_hold;
    psel_i && penable_i |=> $stable(prdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_err;
    psel_i && penable_i && paddr_i[4:2] == 3'h6 |-> pslverr_o;
  endproperty
  a_err: assert property (p_err) else $error("hole not refused");
  property p_ok;
    psel_i && penable_i && paddr_i[7:5] == 3'h0 && paddr_i[4:2] != 3'h6 |-> !pslverr_o;
  endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_setup;
    !penable_i |-> !pslverr_o;
  endproperty
  a_setup: assert property (p_setup) else $error("error outside access");
endmodule

bind ulc_top ulc_chk i_chk
(
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .paddr_i(paddr_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .prdata_o(prdata_o),
  .pslverr_o(pslverr_o),
  .serial_out_o(serial_out_o),
  .infrared_tx_out_o(infrared_tx_out_o)
);

`default_nettype wire

// ---- tb/ulc_peer.sv ----
`timescale 1ns/10ps
`default_nettype none

// Remote serial device; one bit lasts bt clocks.
module ulc_peer
(
  input  wire logic mclk_i,
  input  wire logic line_i,
  output var  logic line_o
);
  int bt = 16;
  initial line_o = 1'b1;

  // Sends the bits of f lowest first, then idles high.
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      line_o <= f[i];
      repeat (bt) @(posedge mclk_i);
    end
    line_o <= 1'b1;
  endtask

  // Bounded wait for a start edge, then n samples at bit centres; unknown on timeout.
  task automatic grab(output logic [11:0] f, input int n);
    int k;
    f = 'x;
    k = 0;
    while (line_i === 1'b1 && k < 40 * bt)
    begin
      @(posedge mclk_i);
      k++;
    end
    if (k < 40 * bt)
    begin
      f = '0;
      repeat (bt / 2) @(posedge mclk_i);
      for (int i = 0; i < n; i++)
      begin
        f[i] = line_i;
        repeat (bt) @(posedge mclk_i);
      end
    end
  endtask

  // Clocks from the end of one start bit to the next start bit; all-ones data only.
  task automatic gap(output int c);
    int k;
    k = 0;
    while (line_i !== 1'b0 && k < 40 * bt)
    begin
      @(posedge mclk_i);
      k++;
    end
    while (line_i !== 1'b1 && k < 80 * bt)
    begin
      @(posedge mclk_i);
      k++;
    end
    c = 0;
    while (line_i !== 1'b0 && c < 40 * bt)
    begin
      @(posedge mclk_i);
      c++;
    end
  endtask
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [31:0] pwd = 32'h0;
  wire  [31:0] prd;
  wire         prdy;
  wire         perr;
  wire         rx_line;
  wire         tx_line;
  wire         ir_line;
  wire         irq;
  logic        err_seen;
  logic [31:0] rd;
  logic [11:0] fr;
  logic [11:0] got;
  logic [15:0] fmt [6] = '{16'h04b5, 16'h0dc6, 16'h1a3c, 16'h2b7e, 16'h3fe1, 16'h075a};
  // Line control and the expected high run in clocks at divisor one.
  logic [15:0] stp [3] = '{16'h0469, 16'h07a1, 16'h0391};
  int          nb;
  int          fail_count = 0;
  int          num_checks = 0;

  // Half period of 25 ns gives 20 MHz.
  always #25 mclk_i = ~mclk_i;

  ulc_top i_dut
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .paddr_i(paddr),
    .psel_i(psel),
    .penable_i(pen),
    .pwrite_i(pwr),
    .pwdata_i(pwd),
    .prdata_o(prd),
    .pready_o(prdy),
    .pslverr_o(perr),
    .serial_in_i(rx_line),
    .serial_out_o(tx_line),
    .infrared_tx_out_o(ir_line),
    .irq_o(irq)
  );

  ulc_peer i_peer
  (
    .mclk_i(mclk_i),
    .line_i(tx_line),
    .line_o(rx_line)
  );

  ////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Case equality so that an unknown never passes.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One transfer; the request stands until pready is sampled high, then one idle edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    paddr <= a;
    pwr <= w;
    pwd <= {24'h0, d};
    psel <= 1'b1;
    @(posedge mclk_i);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (prdy !== 1'b1 && k < 50);
    rd = prd;
    err_seen = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 50)
    begin
      fail_count++;
      close_out();
    end
    @(posedge mclk_i);
  endtask

  // Expected frame lowest bit first: start, data, parity, first stop.
  function automatic void mk(input logic [7:0] lc, input logic [7:0] d,
                             output logic [11:0] f, output int n);
    int w;
    w = 5 + lc[1:0];
    f = '0;
    for (int i = 0; i < w; i++)
      f[i + 1] = d[i];
    n = w + 1;
    if (lc[3])
    begin
      f[n] = lc[5] ? ~lc[4] : (^f ^ ~lc[4]);
      n++;
    end
    f[n] = 1'b1;
    n++;
  endfunction

  // Main sequence.
  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    apb(8'h0c, 1'b0, 8'h00);
    check("lcr reset", rd, 32'h0);
    apb(8'h14, 1'b0, 8'h00);
    check("status reset", rd, 32'h60);
    apb(8'h18, 1'b0, 8'h00);
    check("hole error", {31'h0, err_seen}, 32'h1);
    apb(8'h0c, 1'b1, 8'h83);
    apb(8'h00, 1'b1, 8'h34);
    apb(8'h04, 1'b1, 8'h12);
    apb(8'h00, 1'b0, 8'h00);
    check("divisor low", rd, 32'h34);
    apb(8'h04, 1'b0, 8'h00);
    check("divisor high", rd, 32'h12);
    apb(8'h00, 1'b1, 8'h01);
    apb(8'h04, 1'b1, 8'h00);
    apb(8'h0c, 1'b1, 8'h43);
    check("ir silent", {31'h0, ir_line}, 32'h0);
    check("line idle", {31'h0, tx_line}, 32'h1);
    apb(8'h0c, 1'b1, 8'h03);
    check("ir restored", {31'h0, ir_line}, 32'h1);
    apb(8'h04, 1'b0, 8'h00);
    check("enables", rd, 32'h0);
    // Every length, parity mode and stop choice, out and back in.
    for (int i = 0; i < 6; i++)
    begin
      apb(8'h0c, 1'b1, fmt[i][15:8]);
      apb(8'h00, 1'b1, fmt[i][7:0]);
      mk(fmt[i][15:8], fmt[i][7:0], fr, nb);
      i_peer.grab(got, nb);
      check("tx frame", got, fr);
      i_peer.send(fr, nb);
      apb(8'h00, 1'b0, 8'h00);
      check("rx data", rd, fmt[i][7:0] & (8'hff >> (3 - fmt[i][9:8])));
      apb(8'h14, 1'b0, 8'h00);
      check("rx errors", rd[3:1], 32'h0);
    end
    // A bad parity bit is flagged; the interrupt is masked, raised, then cleared.
    apb(8'h0c, 1'b1, 8'h1b);
    mk(8'h1b, 8'h81, fr, nb);
    fr[9] = ~fr[9];
    i_peer.send(fr, nb);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(8'h14, 1'b0, 8'h00);
    check("parity flag", rd[3:1], 32'h2);
    check("rx held", rd[0], 32'h1);
    apb(8'h04, 1'b1, 8'h04);
    check("irq raised", {31'h0, irq}, 32'h1);
    apb(8'h08, 1'b1, 8'h04);
    check("irq cleared", {31'h0, irq}, 32'h0);
    apb(8'h08, 1'b0, 8'h00);
    check("events left", rd, 32'h3);
    // A receive flush empties the queue that still holds the bad character.
    apb(8'h10, 1'b1, 8'h02);
    apb(8'h14, 1'b0, 8'h00);
    check("rx flushed", rd[0], 32'h0);
    // Stop length: two all-ones characters back to back, so the high run from
    // the first start bit to the second is the data, the stop and one idle tick.
    for (int j = 0; j < 3; j++)
    begin
      apb(8'h0c, 1'b1, stp[j][15:8]);
      apb(8'h00, 1'b1, 8'hff);
      apb(8'h00, 1'b1, 8'hff);
      i_peer.gap(nb);
      check("stop run", nb, {24'h0, stp[j][7:0]});
      repeat (200) @(posedge mclk_i);
    end
    // Fixed MIDI rate: forty clocks a tick.
    apb(8'h10, 1'b1, 8'h01);
    apb(8'h0c, 1'b1, 8'h00);
    apb(8'h00, 1'b1, 8'h13);
    i_peer.bt = 640;
    mk(8'h00, 8'h13, fr, nb);
    i_peer.grab(got, nb);
    check("midi frame", got, fr);
    close_out();
  end
endmodule

`default_nettype wire
